// ---- core/cpu_status_flags_bank_select.sv ----
// Status register, bank select, counter high latch and flag ALU
`timescale 1ns/1ps
module cpu_status_flags_bank_select (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_ce,
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_clear_file_instruction,
  input  wire logic [2:0] i_alu_op,
  input  wire logic [7:0] i_alu_a,
  input  wire logic [7:0] i_alu_b,
  input  wire logic       i_watchdog_clear,
  input  wire logic       i_sleep,
  input  wire logic       i_watchdog_timeout,
  input  wire logic [6:0] i_dir_offset,
  input  wire logic [7:0] i_ind_ptr,
  output logic [7:0]      o_rdata,
  output logic [7:0]      o_alu_result,
  output logic [8:0]      o_direct_addr,
  output logic [8:0]      o_indirect_addr,
  output logic [12:0]     o_pc,
  output logic            o_irq
);
  logic       rst_meta_n;
  logic       rst_n;
  logic [7:0] status;
  logic [4:0] pc_high_holding_latch;
  logic [12:0] pc;
  logic [3:0] irq_stat;
  logic [3:0] irq_mask;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Address decode; status answers at its bank 0 and bank 1 images only (0x003, 0x083), not in banks 2 and 3
  wire hit_status = (i_addr == status_pkg::STATUS_ADDR_LO) ||
                    (i_addr == status_pkg::STATUS_ADDR_HI);
  wire hit_latch  = (i_addr == status_pkg::LATCH_ADDR_LO) ||
                    (i_addr == status_pkg::LATCH_ADDR_HI);
  wire hit_istat  = (i_addr == status_pkg::IRQ_STAT_ADDR);
  wire hit_imask  = (i_addr == status_pkg::IRQ_MASK_ADDR);
  wire hit_pc     = (i_addr == status_pkg::PC_ADDR);

  // Flag ALU; subtraction adds the two's complement of the second operand
  wire [7:0] b_eff    = (i_alu_op == status_pkg::ALU_SUB) ? ~i_alu_b : i_alu_b;
  wire       cin      = (i_alu_op == status_pkg::ALU_SUB);
  wire [4:0] low_sum  = {1'b0, i_alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
  wire [8:0] full_sum = {1'b0, i_alu_a} + {1'b0, b_eff} + {8'h00, cin};
  wire is_arith = (i_alu_op == status_pkg::ALU_ADD) || (i_alu_op == status_pkg::ALU_SUB);
  wire is_rot   = (i_alu_op == status_pkg::ALU_ROL) || (i_alu_op == status_pkg::ALU_ROR);
  wire is_log   = (i_alu_op == status_pkg::ALU_LOG);
  wire [7:0] rot_res = (i_alu_op == status_pkg::ALU_ROL) ?
                       {i_alu_a[6:0], status[status_pkg::BIT_C]} :
                       {status[status_pkg::BIT_C], i_alu_a[7:1]};
  wire [7:0] res = is_arith ? full_sum[7:0] : (is_rot ? rot_res : i_alu_b);
  wire       res_zero  = (res == 8'h00);
  wire       carry_dc  = low_sum[4];
  wire       carry_out = full_sum[8];
  wire       rot_out   = (i_alu_op == status_pkg::ALU_ROL) ?
                         i_alu_a[7] : i_alu_a[0];
  wire       upd_z  = is_arith || is_log || i_clear_file_instruction;
  wire       upd_dc = is_arith;
  wire       upd_c  = is_arith || is_rot;
  wire       upd_any = upd_z || upd_dc || upd_c;
  wire       stat_wr = i_wr && hit_status;

  // Data write to all three flags is blocked when the instruction owns any of them
  wire [7:0] wr_val = i_clear_file_instruction ? 8'h00 : i_wdata;
  wire [7:0] keep_m = {5'h00, {3{upd_any}}};
  wire [7:0] wmask  = status_pkg::STATUS_WR_MASK & ~keep_m;
  wire [7:0] after_wr = stat_wr ? ((status & ~wmask) | (wr_val & wmask)) : status;

  wire next_z  = upd_z  ? (i_clear_file_instruction ? 1'b1 : res_zero) : after_wr[status_pkg::BIT_Z];
  wire next_dc = upd_dc ? carry_dc : after_wr[status_pkg::BIT_DCARRY];
  wire next_c  = is_arith ? carry_out : (is_rot ? rot_out : after_wr[status_pkg::BIT_C]);
  // Timeout wins over clear/sleep if both arrive together
  wire next_to = i_watchdog_timeout ? 1'b0 :
                 ((i_watchdog_clear || i_sleep) ? 1'b1 : status[status_pkg::BIT_TO]);
  wire next_pd = i_sleep ? 1'b0 :
                 (i_watchdog_clear ? 1'b1 : status[status_pkg::BIT_PWRDN]);
  wire [7:0] next_status = {after_wr[7:5], next_to, next_pd, next_z, next_dc, next_c};

  wire [3:0] irq_evt = {is_arith && carry_out, upd_z && res_zero && !i_clear_file_instruction,
                        i_sleep, i_watchdog_timeout};
  wire [3:0] irq_clr = (i_wr && hit_istat) ? i_wdata[3:0] : 4'h0;
  wire [3:0] next_irq_stat = (irq_stat & ~irq_clr) | irq_evt;

  wire [7:0] rd_mux = hit_status ? status :
                      hit_latch  ? {3'h0, pc_high_holding_latch} :
                      hit_istat  ? {4'h0, irq_stat} :
                      hit_imask  ? {4'h0, irq_mask} : 8'h00;

  // Bank mapping; both bank bits (6:5) select the direct bank, bit 7 the indirect bank
  wire [8:0] next_dir = {status[status_pkg::BIT_BANK_HI], status[status_pkg::BIT_BANK_LO],
                         i_dir_offset};
  wire [8:0] next_ind = {status[status_pkg::BIT_IND_BANK], i_ind_ptr};

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status                <= status_pkg::STATUS_RESET;
      pc_high_holding_latch <= status_pkg::LATCH_RESET;
      pc                    <= status_pkg::PC_RESET;
      irq_stat              <= status_pkg::IRQ_RESET;
      irq_mask              <= status_pkg::IRQ_RESET;
      o_rdata               <= 8'h00;
      o_alu_result          <= 8'h00;
      o_direct_addr         <= 9'h000;
      o_indirect_addr       <= 9'h000;
      o_irq                 <= 1'b0;
    end else if (i_ce) begin
      status   <= next_status;
      irq_stat <= next_irq_stat;
      o_irq    <= |(next_irq_stat & irq_mask);
      if (i_wr && hit_imask) begin
        irq_mask <= i_wdata[3:0];
      end
      if (i_wr && hit_latch) begin
        pc_high_holding_latch <= i_wdata[4:0];
      end
      if (i_wr && hit_pc) begin
        pc <= {pc_high_holding_latch, i_wdata};
      end
      o_rdata         <= i_rd ? rd_mux : 8'h00;
      o_alu_result    <= res;
      o_direct_addr   <= next_dir;
      o_indirect_addr <= next_ind;
    end
  end

  assign o_pc = pc;

  ro_flags_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && !i_watchdog_timeout && !i_sleep && !i_watchdog_clear) |=>
      status[4:3] == $past(status[4:3]))
    else $error("read-only flags changed by write");
  clear_file_instruction_val_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && i_clear_file_instruction && !is_arith && !is_rot) |=>
      status[7:5] == 3'b000 && status[status_pkg::BIT_Z])
    else $error("clear-file result wrong");
  flag_block_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && is_arith) |=> status[0] == $past(carry_out))
    else $error("data write reached carry");
  timeout_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_watchdog_timeout) |=> !status[status_pkg::BIT_TO])
    else $error("timeout flag not cleared");
  sleep_pd_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_sleep && !i_watchdog_timeout) |=> !status[3] && status[4])
    else $error("sleep flags wrong");
  zero_flag_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && is_log && !i_clear_file_instruction) |=> status[2] == (o_alu_result == 8'h00))
    else $error("zero flag mismatch");
  sub_borrow_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_SUB) |=>
      status[0] == ($past(i_alu_a) >= $past(i_alu_b)))
    else $error("borrow polarity wrong");
  rot_carry_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ROL) |=> status[0] == $past(i_alu_a[7]))
    else $error("rotate carry wrong");
  mirror_rd_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_rd && hit_status) |=> o_rdata == $past(status))
    else $error("status image read wrong");
  bank_dir_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=> o_direct_addr[8:7] == $past(status[6:5]))
    else $error("direct bank wrong");

  // Clock enable freezes all state
  ce_status_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_ce |=>
      status == $past(status))
    else $error("status moved while frozen");
  ce_latch_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_ce |=>
      pc_high_holding_latch == $past(pc_high_holding_latch))
    else $error("latch moved while frozen");
  ce_pc_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_ce |=>
      pc == $past(pc))
    else $error("counter moved while frozen");
  ce_irq_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    !i_ce |=>
      irq_stat == $past(irq_stat))
    else $error("irq status moved while frozen");

  // Bank address outputs
  dir_offset_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=>
      o_direct_addr[6:0] == $past(i_dir_offset))
    else $error("direct offset wrong");
  bank_ind_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    i_ce |=>
      o_indirect_addr == {$past(status[7]), $past(i_ind_ptr)})
    else $error("indirect bank wrong");

  // Register writes and flag ownership
  wr_bank_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && !i_clear_file_instruction) |=>
      status[7:5] == $past(i_wdata[7:5]))
    else $error("bank bits not written");
  wr_flags_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && !upd_any) |=>
      status[2:0] == $past(i_wdata[2:0]))
    else $error("plain flag write lost");
  clear_file_instruction_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && i_clear_file_instruction && i_alu_op == status_pkg::ALU_NONE) |=>
      status[1:0] == $past(status[1:0]))
    else $error("clear-file touched carries");
  clear_file_instruction_ro_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && i_clear_file_instruction && !i_watchdog_timeout && !i_sleep && !i_watchdog_clear) |=>
      status[4:3] == $past(status[4:3]))
    else $error("clear-file touched reset flags");
  rot_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && is_rot) |=>
      status[2:1] == $past(status[2:1]))
    else $error("rotate write reached flags");
  log_keep_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && stat_wr && is_log) |=>
      status[1:0] == $past(status[1:0]))
    else $error("logic write reached carries");
  alu_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_NONE && !stat_wr && !i_clear_file_instruction) |=>
      status[2:0] == $past(status[2:0]))
    else $error("flags moved without cause");

  // Arithmetic and rotate flags and results
  add_carry_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ADD) |=>
      status[0] == (({1'b0, $past(i_alu_a)} + {1'b0, $past(i_alu_b)}) > 9'h0FF))
    else $error("add carry wrong");
  add_dc_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ADD) |=>
      status[1] == (({1'b0, $past(i_alu_a[3:0])} + {1'b0, $past(i_alu_b[3:0])}) > 5'h0F))
    else $error("add digit carry wrong");
  sub_dc_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_SUB) |=>
      status[1] == ($past(i_alu_a[3:0]) >= $past(i_alu_b[3:0])))
    else $error("digit borrow polarity wrong");
  add_res_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ADD) |=>
      o_alu_result == 8'($past(i_alu_a) + $past(i_alu_b)))
    else $error("add result wrong");
  sub_res_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_SUB) |=>
      o_alu_result == 8'($past(i_alu_a) - $past(i_alu_b)))
    else $error("subtract result wrong");
  arith_zero_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && is_arith) |=>
      status[2] == (o_alu_result == 8'h00))
    else $error("arith zero flag wrong");
  ror_carry_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ROR) |=>
      status[0] == $past(i_alu_a[0]))
    else $error("right rotate carry wrong");
  rol_res_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ROL) |=>
      o_alu_result == {$past(i_alu_a[6:0]), $past(status[0])})
    else $error("left rotate result wrong");
  ror_res_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_alu_op == status_pkg::ALU_ROR) |=>
      o_alu_result == {$past(status[0]), $past(i_alu_a[7:1])})
    else $error("right rotate result wrong");

  // Reset-cause flags
  wdt_clr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_watchdog_clear && !i_watchdog_timeout && !i_sleep) |=>
      status[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  to_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !i_watchdog_timeout && !i_watchdog_clear && !i_sleep) |=>
      status[4] == $past(status[4]))
    else $error("timeout flag moved");
  pd_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !i_watchdog_clear && !i_sleep) |=>
      status[3] == $past(status[3]))
    else $error("powerdown flag moved");

  // Counter and holding latch
  latch_wr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_wr && hit_latch) |=>
      pc_high_holding_latch == $past(i_wdata[4:0]))
    else $error("latch write lost");
  pc_wr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_wr && hit_pc) |=>
      pc == {$past(pc_high_holding_latch), $past(i_wdata)})
    else $error("counter load wrong");
  pc_hold_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !(i_wr && hit_pc)) |=>
      pc == $past(pc))
    else $error("counter upper bits reached directly");

  // Read port
  rd_idle_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !i_rd) |=>
      o_rdata == 8'h00)
    else $error("read data outside read");
  rd_latch_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_rd && hit_latch) |=>
      o_rdata == {3'h0, $past(pc_high_holding_latch)})
    else $error("latch read wrong");
  rd_unmap_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_rd && !(hit_status || hit_latch || hit_istat || hit_imask)) |=>
      o_rdata == 8'h00)
    else $error("unmapped read not zero");
  rd_imask_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_rd && hit_imask) |=>
      o_rdata == {4'h0, $past(irq_mask)})
    else $error("mask read wrong");
  rd_istat_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_rd && hit_istat) |=>
      o_rdata == {4'h0, $past(irq_stat)})
    else $error("irq status read wrong");

  // Interrupt status, mask and level
  irq_set_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_watchdog_timeout) |=>
      irq_stat[status_pkg::IRQ_TIMEOUT])
    else $error("timeout event not latched");
  irq_clr_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_wr && hit_istat && irq_evt == 4'h0) |=>
      (irq_stat & $past(i_wdata[3:0])) == 4'h0)
    else $error("irq clear lost");
  irq_mask_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && i_wr && hit_imask) |=>
      irq_mask == $past(i_wdata[3:0]))
    else $error("mask write lost");
  irq_level_a: assert property (@(posedge i_clk) disable iff (!rst_n)
    (i_ce && !(i_wr && hit_imask)) |=>
      o_irq == |(irq_stat & irq_mask))
    else $error("irq level wrong");
endmodule // cpu_status_flags_bank_select

// ---- core/status_pkg.sv ----
// Constants for the processor status and bank select block
package status_pkg;
  localparam logic [8:0] STATUS_ADDR_LO   = 9'h003;
  localparam logic [8:0] STATUS_ADDR_HI   = 9'h083;
  localparam logic [8:0] LATCH_ADDR_LO    = 9'h00A;
  localparam logic [8:0] LATCH_ADDR_HI    = 9'h08A;
  localparam logic [8:0] IRQ_STAT_ADDR    = 9'h1F0;
  localparam logic [8:0] IRQ_MASK_ADDR    = 9'h1F1;
  localparam logic [8:0] PC_ADDR          = 9'h1F2;
  localparam int         BIT_IND_BANK     = 7;
  localparam int         BIT_BANK_HI      = 6;
  localparam int         BIT_BANK_LO      = 5;
  localparam int         BIT_TO           = 4;
  localparam int         BIT_PWRDN        = 3;
  localparam int         BIT_Z            = 2;
  localparam int         BIT_DCARRY       = 1;
  localparam int         BIT_C            = 0;
  localparam logic [7:0] STATUS_RESET     = 8'h18;
  localparam logic [7:0] STATUS_WR_MASK   = 8'hE7;
  localparam logic [7:0] ARITH_MASK       = 8'h07;
  localparam logic [4:0] LATCH_RESET      = 5'h00;
  localparam logic [12:0] PC_RESET        = 13'h0000;
  localparam logic [3:0] IRQ_RESET        = 4'h0;
  localparam int         IRQ_TIMEOUT      = 0;
  localparam int         IRQ_SLEEP        = 1;
  localparam int         IRQ_ZERO         = 2;
  localparam int         IRQ_CARRY        = 3;
  typedef enum logic [2:0] {
    ALU_NONE = 3'b000,
    ALU_ADD  = 3'b001,
    ALU_SUB  = 3'b010,
    ALU_LOG  = 3'b011,
    ALU_ROL  = 3'b100,
    ALU_ROR  = 3'b101
  } alu_op_t;
endpackage

// ---- verif/alu_ref.sv ----
// Reference model of the core ALU result and flags
`timescale 1ns/1ps
module alu_ref (
  input  wire logic [2:0] i_op,
  input  wire logic [7:0] i_a,
  input  wire logic [7:0] i_b,
  input  wire logic [2:0] i_flags,
  output logic      [7:0] o_res,
  output logic      [2:0] o_flags
);
  logic [7:0] nb;
  logic [8:0] sum;
  logic [4:0] dsum;
  always_comb begin
    nb = (i_op == 3'h2) ? ~i_b : i_b;
    sum = {1'b0, i_a} + {1'b0, nb} + 9'(i_op == 3'h2);
    dsum = {1'b0, i_a[3:0]} + {1'b0, nb[3:0]} + 5'(i_op == 3'h2);
    o_res = sum[7:0];
    o_flags = {sum[7:0] == 8'h00, dsum[4], sum[8]};
    if (i_op == 3'h3) o_res = i_b;
    if (i_op == 3'h4) o_res = {i_a[6:0], i_flags[0]};
    if (i_op == 3'h5) o_res = {i_flags[0], i_a[7:1]};
    if (i_op == 3'h3) o_flags = {i_b == 8'h00, i_flags[1:0]};
    if (i_op > 3'h3) o_flags = {i_flags[2:1], i_op[0] ? i_a[0] : i_a[7]};
    if (i_op == 3'h0) o_flags = i_flags;
  end
endmodule // alu_ref

// ---- verif/tb_top.sv ----
// Self-checking bench for the status, bank select and latch block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic        clk = 0, arst_n = 0, wr = 0, rd = 0, clear_file_instruction = 0, wclr = 0, slp = 0, wto = 0, ce = 1;
  logic [8:0]  addr = '0, daddr, iaddr;
  logic [7:0]  wdata = '0, a = '0, b = '0, ptr = '0, st = 8'h18, r, e, qe, mres, rdata, alu_res;
  logic [6:0]  off = '0;
  logic [2:0]  op = '0, mfl;
  logic [12:0] pc;
  logic        irq, rd_seen = 0;
  logic [7:0]  q[$];
  int          fail_count = 0, num_checks = 0;
  always #2 clk = ~clk;
  cpu_status_flags_bank_select uut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_clear_file_instruction(clear_file_instruction), .i_alu_op(op),
    .i_alu_a(a), .i_alu_b(b), .i_watchdog_clear(wclr), .i_sleep(slp),
    .i_watchdog_timeout(wto),
    .i_dir_offset(off), .i_ind_ptr(ptr), .o_rdata(rdata), .o_alu_result(alu_res),
    .o_direct_addr(daddr), .o_indirect_addr(iaddr), .o_pc(pc), .o_irq(irq));
  alu_ref core (.i_op(op), .i_a(a), .i_b(b), .i_flags(st[2:0]), .o_res(mres), .o_flags(mfl));
  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_seen && q.size() > 0) begin
      qe = q.pop_front();
      `CHK(rdata, qe)
    end
    rd_seen <= rd;
  end
  task automatic end_sim();
    if (q.size() != 0) fail_count++;
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic put(input logic [8:0] ad, input logic [7:0] d, input logic [2:0] o = 0,
                     input logic c = 0, input logic [7:0] x = 0, input logic [7:0] y = 0);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1;
    op <= o;
    clear_file_instruction <= c;
    a <= x;
    b <= y;
    @(posedge clk);
    r = mres;
    e = {c ? 3'h0 : d[7:5], st[4:3], (o != 0) ? mfl : (c ? {1'b1, st[1:0]} : d[2:0])};
    if (ad == status_pkg::STATUS_ADDR_LO || ad == status_pkg::STATUS_ADDR_HI) st = e;
    wr <= 0;
    op <= 0;
    clear_file_instruction <= 0;
    #1;
    if (o != 0) `CHK(alu_res, r)
  endtask
  task automatic get(input logic [8:0] ad, input logic [7:0] x);
    @(posedge clk);
    addr <= ad;
    rd <= 1;
    q.push_back(x);
    @(posedge clk);
    rd <= 0;
  endtask
  task automatic ev(input int k);
    @(posedge clk);
    wclr <= (k == 0);
    slp <= (k == 1);
    wto <= (k == 2);
    @(posedge clk);
    st[4:3] = (k == 0) ? 2'b11 : (k == 1) ? 2'b10 : {1'b0, st[3]};
    wclr <= 0;
    slp <= 0;
    wto <= 0;
  endtask
  initial begin
    r = $urandom(26);
    repeat (10) @(posedge clk);
    arst_n <= 1;
    repeat (3) @(posedge clk);
    get(status_pkg::STATUS_ADDR_LO, status_pkg::STATUS_RESET);
    put(status_pkg::STATUS_ADDR_LO, 8'h00);
    get(status_pkg::STATUS_ADDR_HI, st);
    for (int i = 0; i < 8; i++) begin
      off <= 7'($urandom);
      ptr <= 8'($urandom);
      put(status_pkg::STATUS_ADDR_HI, {2'b00, i[0], 5'h07});
      repeat (2) @(posedge clk);
      `CHK(daddr, {st[6:5], off})
      `CHK(iaddr, {st[7], ptr})
      get(status_pkg::STATUS_ADDR_LO, st);
    end
    put(status_pkg::STATUS_ADDR_LO, 8'hFF, 3'h0, 1'b1);
    get(status_pkg::STATUS_ADDR_LO, st);
    for (int k = 2; k >= 0; k--) begin
      ev(k);
      get(status_pkg::STATUS_ADDR_HI, st);
    end
    for (int i = 0; i < 40; i++) begin
      r = 8'($urandom);
      e = (i % 3 == 0) ? -r : 8'($urandom);
      put(status_pkg::STATUS_ADDR_LO, 8'($urandom) & 8'h3F, 3'(1 + i % 5), 1'b0, r, e);
      get(status_pkg::STATUS_ADDR_LO, st);
    end
    put(status_pkg::LATCH_ADDR_LO, 8'h15);
    get(status_pkg::LATCH_ADDR_HI, 8'h15);
    put(status_pkg::PC_ADDR, 8'hA5);
    `CHK(pc, {5'h15, 8'hA5})
    ce <= 0;
    put(status_pkg::LATCH_ADDR_LO, 8'h0A);
    ce <= 1;
    get(status_pkg::LATCH_ADDR_HI, 8'h15);
    get(9'h100, 8'h00);
    put(status_pkg::IRQ_STAT_ADDR, 8'h0F);
    put(status_pkg::IRQ_MASK_ADDR, 8'h01);
    get(status_pkg::IRQ_STAT_ADDR, 8'h00);
    `CHK(irq, 1'b0)
    ev(2);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    put(status_pkg::IRQ_MASK_ADDR, 8'h0E);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    put(status_pkg::IRQ_MASK_ADDR, 8'h01);
    put(status_pkg::IRQ_STAT_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    get(status_pkg::IRQ_STAT_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule // tb_top
